// ==== hw/hvi_port_input_control.sv ====
// register file, pad control, input synchroniser and edge interrupt for two high-voltage pins
// Operation
// - digital mode reads synchronized pin state
// - otherwise input bit reads one; here analog test override in run without direct connection reads the pin too
// - input register read-only, upper bits zero
// - only two pin bits, 1 down to 0
// - analog pulldown default, pullup when enabled
// - pull select one pullup, zero pulldown; here pullup also needs test enable in run, else pulldown
// - polarity one rising, zero falling edge
// - bypass acts only with direct connection
// - bypass one skips impedance converter
// - direct connection acts only in analog
// - direct one skips voltage divider
// - digital enable one turns buffer on
// - analog forces buffer off in run
// - digital enable zero disables input
// - test enable forces buffer in run; here only in analog mode and without direct connection
// - analog mode overrides digital input buffer; here only in run, in stop the buffer follows digital enable
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps

module hvi_port_input_control #(
   parameter int unsigned NUM_PINS = hvi_pkg::NUM_PINS
) (
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       sys_rst,
   // classic wishbone slave
   input  wire logic [hvi_pkg::ADR_W-1:0]  wb_adr_i,
   input  wire logic [hvi_pkg::DAT_W-1:0]  wb_dat_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic                       wb_we_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   output logic      [hvi_pkg::DAT_W-1:0]  wb_dat_o,
   output logic                            wb_ack_o,
   // neighbouring port controls
   input  wire logic [1:0]                 analog_mode_enable,
   input  wire logic [1:0]                 input_buffer_test_enable,
   input  wire logic                       reduced_power_stop,
   // pad side
   input  wire logic [1:0]                 high_voltage_input_pin,
   output hvi_pkg::hvi_pad_t               pad_ctrl,
   // interrupt
   output logic                            irq
);

   hvi_pkg::hvi_cfg_t   cfg;
   logic [1:0]          irq_status;
   logic [1:0]          irq_mask;
   logic [1:0]          sync_meta;
   logic [1:0]          sync_pin;
   logic [1:0]          sync_prev;
   logic [1:0]          live_read;
   logic [1:0]          input_state;
   logic [1:0]          edge_event;
   logic [1:0]          run_test;
   logic [1:0]          next_ibe;
   logic [1:0]          next_pullup;
   logic [1:0]          next_direct;
   logic [hvi_pkg::IDX_W-1:0] idx;
   logic                bus_req;
   logic                wr_take;
   logic [1:0]          wr_bits;
   logic [hvi_pkg::DAT_W-1:0] next_rdata;

   function automatic logic hit(input logic [hvi_pkg::IDX_W-1:0] a,
                                input logic [hvi_pkg::IDX_W-1:0] r);
      hit = (a == r);
   endfunction

   // ---------------- bus slave ----------------
   assign idx     = wb_adr_i[hvi_pkg::ADR_W-1:2];
   assign bus_req = wb_cyc_i & wb_stb_i;
   // write lands on the same edge at which the master sees ack
   assign wr_take = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign wr_bits = wb_dat_i[hvi_pkg::PIN_MSB:hvi_pkg::PIN_LSB];

   // one wait state, ack dropped the cycle after it is given
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
      end
   end

   always_comb begin
      next_rdata = '0;
      if (hit(idx, hvi_pkg::IDX_INPUT_STATE)) begin
         next_rdata[1:0] = input_state;
      end else if (hit(idx, hvi_pkg::IDX_PULL_SELECT)) begin
         next_rdata[1:0] = cfg.pull_select;
      end else if (hit(idx, hvi_pkg::IDX_EDGE_POLARITY)) begin
         next_rdata[1:0] = cfg.edge_polarity;
      end else if (hit(idx, hvi_pkg::IDX_CONV_BYPASS)) begin
         next_rdata[1:0] = cfg.converter_bypass;
      end else if (hit(idx, hvi_pkg::IDX_DIRECT_CONN)) begin
         next_rdata[1:0] = cfg.direct_connect;
      end else if (hit(idx, hvi_pkg::IDX_DIGITAL_EN)) begin
         next_rdata[1:0] = cfg.digital_input_enable;
      end else if (hit(idx, hvi_pkg::IDX_IRQ_STATUS)) begin
         next_rdata[1:0] = irq_status;
      end else if (hit(idx, hvi_pkg::IDX_IRQ_MASK)) begin
         next_rdata[1:0] = irq_mask;
      end
   end

   // unmapped addresses answer with zero
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wb_dat_o <= '0;
      end else if (bus_req & ~wb_ack_o) begin
         wb_dat_o <= next_rdata;
      end
   end

   // input state register has no write path at all
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg.pull_select          <= hvi_pkg::RST_PULL_SELECT;
         cfg.edge_polarity        <= hvi_pkg::RST_EDGE_POLARITY;
         cfg.converter_bypass     <= hvi_pkg::RST_CONV_BYPASS;
         cfg.direct_connect       <= hvi_pkg::RST_DIRECT_CONN;
         cfg.digital_input_enable <= hvi_pkg::RST_DIGITAL_EN;
         irq_mask                 <= hvi_pkg::RST_IRQ_MASK;
      end else if (wr_take) begin
         if (hit(idx, hvi_pkg::IDX_PULL_SELECT)) begin
            cfg.pull_select <= wr_bits;
         end
         if (hit(idx, hvi_pkg::IDX_EDGE_POLARITY)) begin
            cfg.edge_polarity <= wr_bits;
         end
         if (hit(idx, hvi_pkg::IDX_CONV_BYPASS)) begin
            cfg.converter_bypass <= wr_bits;
         end
         if (hit(idx, hvi_pkg::IDX_DIRECT_CONN)) begin
            cfg.direct_connect <= wr_bits;
         end
         if (hit(idx, hvi_pkg::IDX_DIGITAL_EN)) begin
            cfg.digital_input_enable <= wr_bits;
         end
         if (hit(idx, hvi_pkg::IDX_IRQ_MASK)) begin
            irq_mask <= wr_bits;
         end
      end
   end

   // ---------------- pad control ----------------
   assign run_test = input_buffer_test_enable & ~{2{reduced_power_stop}};

   always_comb begin
      // buffer follows enable unless analog in run mode takes it
      if (reduced_power_stop) begin
         next_ibe = cfg.digital_input_enable;
      end else begin
         next_ibe = (cfg.digital_input_enable & ~analog_mode_enable)
                  | (analog_mode_enable & run_test & ~cfg.direct_connect);
      end
      next_pullup = analog_mode_enable & cfg.pull_select & run_test;
      next_direct = analog_mode_enable & cfg.direct_connect;
   end

   // registered so the pad never sees decode glitches
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pad_ctrl <= '0;
      end else begin
         pad_ctrl.input_buffer_enable <= next_ibe;
         pad_ctrl.pullup_enable       <= next_pullup;
         pad_ctrl.pulldown_enable     <= analog_mode_enable & ~next_pullup;
         pad_ctrl.direct_connect      <= next_direct;
         pad_ctrl.converter_bypass    <= next_direct & cfg.converter_bypass;
      end
   end

   // ---------------- input path ----------------
   // first stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sync_meta <= hvi_pkg::RST_SYNC;
         sync_pin  <= hvi_pkg::RST_SYNC;
         sync_prev <= hvi_pkg::RST_SYNC;
      end else begin
         sync_meta <= high_voltage_input_pin;
         sync_pin  <= sync_meta;
         sync_prev <= sync_pin;
      end
   end

   // live only in digital mode or test override in run
   assign live_read   = (cfg.digital_input_enable & ~analog_mode_enable)
                      | (analog_mode_enable & run_test & ~cfg.direct_connect);
   assign input_state = (live_read & sync_pin) | ~live_read;

   // ---------------- interrupt ----------------
   assign edge_event = live_read
                     & ((cfg.edge_polarity  & sync_pin  & ~sync_prev)
                     |  (~cfg.edge_polarity & ~sync_pin & sync_prev));

   // a new edge outranks a simultaneous write-one clear
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_status <= hvi_pkg::RST_IRQ_STATUS;
      end else begin
         irq_status <= (irq_status
                       & ~({2{wr_take & hit(idx, hvi_pkg::IDX_IRQ_STATUS)}} & wr_bits))
                       | edge_event;
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ---------------- checks ----------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   property p_digital_read;
      (cfg.digital_input_enable[0] & ~analog_mode_enable[0]) |->
         input_state[0] == sync_pin[0];
   endproperty
   a_digital_read : assert property (p_digital_read)
      else $error("digital pin 0 read not synchronized state");

   property p_read_one;
      (~cfg.digital_input_enable[1] & ~analog_mode_enable[1]) |-> input_state[1];
   endproperty
   a_read_one : assert property (p_read_one)
      else $error("non-digital pin 1 must read one");

   property p_ro_upper;
      (bus_req & ~wb_ack_o & ~wb_we_i & hit(idx, hvi_pkg::IDX_INPUT_STATE)) |=>
         wb_ack_o && wb_dat_o[31:2] == '0 && wb_dat_o[1:0] == $past(input_state);
   endproperty
   a_ro_upper : assert property (p_ro_upper)
      else $error("input state read wrong or upper bits set");

   property p_pullup;
      ##1 pad_ctrl.pullup_enable[0] ==
         ($past(analog_mode_enable[0]) & $past(cfg.pull_select[0])
          & $past(input_buffer_test_enable[0]) & ~$past(reduced_power_stop));
   endproperty
   a_pullup : assert property (p_pullup)
      else $error("pullup control mismatch on pin 0");

   property p_pull_exclusive;
      !(pad_ctrl.pullup_enable[1] && pad_ctrl.pulldown_enable[1]);
   endproperty
   a_pull_exclusive : assert property (p_pull_exclusive)
      else $error("pullup and pulldown both on pin 1");

   property p_rise_event;
      (cfg.edge_polarity[0] & live_read[0] & sync_pin[0] & ~sync_prev[0]) |=>
         irq_status[0];
   endproperty
   a_rise_event : assert property (p_rise_event)
      else $error("rising edge lost on pin 0");

   property p_no_fall_when_rise;
      (cfg.edge_polarity[0] & ~sync_pin[0] & sync_prev[0] & ~irq_status[0]) |=>
         !irq_status[0];
   endproperty
   a_no_fall_when_rise : assert property (p_no_fall_when_rise)
      else $error("falling edge flagged with rising polarity");

   property p_bypass;
      pad_ctrl.converter_bypass[0] |->
         ($past(cfg.direct_connect[0]) & $past(analog_mode_enable[0]));
   endproperty
   a_bypass : assert property (p_bypass)
      else $error("bypass active without direct connection");

   property p_direct;
      pad_ctrl.direct_connect[1] |-> $past(analog_mode_enable[1]);
   endproperty
   a_direct : assert property (p_direct)
      else $error("direct connection outside analog mode");

   property p_run_analog_off;
      (analog_mode_enable[0] & ~reduced_power_stop & ~input_buffer_test_enable[0]) |=>
         !pad_ctrl.input_buffer_enable[0];
   endproperty
   a_run_analog_off : assert property (p_run_analog_off)
      else $error("buffer on in run analog mode without test");

   property p_stop_follows;
      reduced_power_stop |=> pad_ctrl.input_buffer_enable == $past(cfg.digital_input_enable);
   endproperty
   a_stop_follows : assert property (p_stop_follows)
      else $error("stop mode buffer does not follow enable");

   property p_disabled;
      (~cfg.digital_input_enable[1] & ~analog_mode_enable[1]) |=>
         !pad_ctrl.input_buffer_enable[1];
   endproperty
   a_disabled : assert property (p_disabled)
      else $error("buffer on with digital input disabled");

   property p_test_force;
      (analog_mode_enable[1] & input_buffer_test_enable[1] & ~reduced_power_stop
       & ~cfg.direct_connect[1]) |=> pad_ctrl.input_buffer_enable[1];
   endproperty
   a_test_force : assert property (p_test_force)
      else $error("test enable did not force buffer");

   property p_sync_delay;
      ##2 sync_pin == $past(high_voltage_input_pin, 2);
   endproperty
   a_sync_delay : assert property (p_sync_delay)
      else $error("synchroniser latency not two cycles");

   property p_cfg_write;
      (wr_take & hit(idx, hvi_pkg::IDX_DIGITAL_EN)) |=>
         cfg.digital_input_enable == $past(wr_bits);
   endproperty
   a_cfg_write : assert property (p_cfg_write)
      else $error("digital enable write not stored");

   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse : assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

   property p_pulldown_default;
      ##1 pad_ctrl.pulldown_enable[1] ==
         ($past(analog_mode_enable[1])
          & ~($past(cfg.pull_select[1]) & $past(input_buffer_test_enable[1])
              & ~$past(reduced_power_stop)));
   endproperty
   a_pulldown_default : assert property (p_pulldown_default)
      else $error("pulldown control mismatch on pin 1");

   property p_upper_zero;
      wb_ack_o |-> wb_dat_o[31:2] == '0;
   endproperty
   a_upper_zero : assert property (p_upper_zero)
      else $error("read data above pin bits not zero");

   property p_bypass_on;
      ##1 pad_ctrl.converter_bypass[1] ==
         ($past(analog_mode_enable[1]) & $past(cfg.direct_connect[1])
          & $past(cfg.converter_bypass[1]));
   endproperty
   a_bypass_on : assert property (p_bypass_on)
      else $error("bypass control mismatch on pin 1");

   property p_direct_on;
      (analog_mode_enable[0] & cfg.direct_connect[0]) |=>
         pad_ctrl.direct_connect[0];
   endproperty
   a_direct_on : assert property (p_direct_on)
      else $error("direct connection not applied on pin 0");

   property p_digital_buffer;
      (cfg.digital_input_enable[0] & ~analog_mode_enable[0]) |=>
         pad_ctrl.input_buffer_enable[0];
   endproperty
   a_digital_buffer : assert property (p_digital_buffer)
      else $error("buffer off with digital input enabled");

   property p_analog_reads_one;
      (analog_mode_enable[0] & ~(input_buffer_test_enable[0] & ~reduced_power_stop
                                 & ~cfg.direct_connect[0])) |-> input_state[0];
   endproperty
   a_analog_reads_one : assert property (p_analog_reads_one)
      else $error("analog pin 0 read not forced to one");

   property p_clear_status;
      (wr_take & hit(idx, hvi_pkg::IDX_IRQ_STATUS) & wr_bits[0] & ~edge_event[0]) |=>
         !irq_status[0];
   endproperty
   a_clear_status : assert property (p_clear_status)
      else $error("write one did not clear status on pin 0");

   property p_edge_sets;
      edge_event[1] |=> irq_status[1];
   endproperty
   a_edge_sets : assert property (p_edge_sets)
      else $error("edge event lost on pin 1");

   c_edge_irq   : cover property (irq ##1 wr_take);
   c_test_read  : cover property (analog_mode_enable[0] & run_test[0] & live_read[0]);
   c_bypass_on  : cover property (pad_ctrl.converter_bypass[1]);
   c_stop_wake  : cover property (reduced_power_stop & pad_ctrl.input_buffer_enable[0]);
   c_fall_flag  : cover property (edge_event[1] ##1 irq_status[1]);

endmodule

// ==== hw/hvi_pkg.sv ====
// constants, register map and carrier types for the high-voltage input port control
package hvi_pkg;

   // port geometry
   localparam int unsigned NUM_PINS   = 2;
   localparam int unsigned ADR_W      = 14;
   localparam int unsigned IDX_W      = 12;
   localparam int unsigned DAT_W      = 32;
   localparam int unsigned REG_W      = 8;

   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_INPUT_STATE   = 12'h331;
   localparam logic [IDX_W-1:0] IDX_PULL_SELECT   = 12'h332;
   localparam logic [IDX_W-1:0] IDX_EDGE_POLARITY = 12'h333;
   localparam logic [IDX_W-1:0] IDX_CONV_BYPASS   = 12'h334;
   localparam logic [IDX_W-1:0] IDX_DIRECT_CONN   = 12'h335;
   localparam logic [IDX_W-1:0] IDX_DIGITAL_EN    = 12'h336;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS    = 12'h337;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK      = 12'h338;

   // field layout: pin bits sit at 1 down to 0
   localparam int unsigned PIN_LSB = 0;
   localparam int unsigned PIN_MSB = 1;

   // reset values
   localparam logic [NUM_PINS-1:0] RST_PULL_SELECT   = 2'h0;
   localparam logic [NUM_PINS-1:0] RST_EDGE_POLARITY = 2'h0;
   localparam logic [NUM_PINS-1:0] RST_CONV_BYPASS   = 2'h0;
   localparam logic [NUM_PINS-1:0] RST_DIRECT_CONN   = 2'h0;
   localparam logic [NUM_PINS-1:0] RST_DIGITAL_EN    = 2'h0;
   localparam logic [NUM_PINS-1:0] RST_IRQ_STATUS    = 2'h0;
   localparam logic [NUM_PINS-1:0] RST_IRQ_MASK      = 2'h0;
   localparam logic [NUM_PINS-1:0] RST_SYNC          = 2'h3;

   // software-owned per-pin configuration
   typedef struct packed {
      logic [NUM_PINS-1:0] pull_select;
      logic [NUM_PINS-1:0] edge_polarity;
      logic [NUM_PINS-1:0] converter_bypass;
      logic [NUM_PINS-1:0] direct_connect;
      logic [NUM_PINS-1:0] digital_input_enable;
   } hvi_cfg_t;

   // controls driven toward the analog pad
   typedef struct packed {
      logic [NUM_PINS-1:0] input_buffer_enable;
      logic [NUM_PINS-1:0] pullup_enable;
      logic [NUM_PINS-1:0] pulldown_enable;
      logic [NUM_PINS-1:0] direct_connect;
      logic [NUM_PINS-1:0] converter_bypass;
   } hvi_pad_t;

endpackage

// ==== verif/hvi_port_input_control_bench.sv ====
// self-checking bench for the high-voltage input port control block
`timescale 1ns/1ps

module hvi_port_input_control_bench;
   // clock, reset and bus
   logic                               sys_clk;
   logic                               sys_rst;
   logic [hvi_pkg::ADR_W-1:0]          wb_adr;
   logic [hvi_pkg::DAT_W-1:0]          wb_dat;
   logic [3:0]                         wb_sel;
   logic                               wb_we;
   logic                               wb_cyc;
   logic                               wb_stb;
   logic [hvi_pkg::DAT_W-1:0]          wb_dat_o;
   logic                               wb_ack_o;
   // port controls and pad
   logic [1:0]                         aen;
   logic [1:0]                         te;
   logic                               stp;
   logic [1:0]                         pin;
   hvi_pkg::hvi_pad_t                  pad_ctrl;
   logic                               irq;
   // bookkeeping
   int                                 errors;
   int                                 n_compared;
   logic [1:0]                         m_cfg [5];
   logic [31:0]                        rd;

   hvi_port_input_control i_dut (
      .sys_clk                  (sys_clk),
      .sys_rst                  (sys_rst),
      .wb_adr_i                 (wb_adr),
      .wb_dat_i                 (wb_dat),
      .wb_sel_i                 (wb_sel),
      .wb_we_i                  (wb_we),
      .wb_cyc_i                 (wb_cyc),
      .wb_stb_i                 (wb_stb),
      .wb_dat_o                 (wb_dat_o),
      .wb_ack_o                 (wb_ack_o),
      .analog_mode_enable       (aen),
      .input_buffer_test_enable (te),
      .reduced_power_stop       (stp),
      .high_voltage_input_pin   (pin),
      .pad_ctrl                 (pad_ctrl),
      .irq                      (irq)
   );

   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      if (errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one classic cycle; wait for ack, release at that edge, idle one cycle
   task automatic wb_xfer(input logic [11:0] idx, input logic we, input logic [31:0] d,
                          input logic [3:0] sel, output logic [31:0] q);
      int n;
      n = 0;
      wb_adr <= {idx, 2'h0};
      wb_we  <= we;
      wb_dat <= d;
      wb_sel <= sel;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
      end
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wb_wr(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] sel);
      logic [31:0] q;
      wb_xfer(idx, 1'b1, d, sel, q);
   endtask

   task automatic wb_rd(input logic [11:0] idx, output logic [31:0] q);
      wb_xfer(idx, 1'b0, 32'h0000_0000, 4'hF, q);
   endtask

   // reference pad controls: cfg order is pull, polarity, bypass, direct, digital enable
   function automatic logic [31:0] exp_pad();
      logic [1:0] ibe;
      logic [1:0] pu;
      ibe = stp ? m_cfg[4] : ((m_cfg[4] & ~aen) | (aen & te & ~m_cfg[3]));
      pu  = aen & m_cfg[0] & te & ~{2{stp}};
      return {22'h0, ibe, pu, aen & ~pu, aen & m_cfg[3], aen & m_cfg[3] & m_cfg[2]};
   endfunction

   function automatic logic [31:0] exp_input();
      logic [1:0] live;
      live = (m_cfg[4] & ~aen) | (aen & te & ~m_cfg[3] & ~{2{stp}});
      return {30'h0, (live & pin) | ~live};
   endfunction

   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      results();
   end

   initial begin
      logic [31:0] d;
      errors     = 0;
      n_compared = 0;
      sys_rst <= 1'b1;
      wb_adr  <= '0;
      wb_dat  <= '0;
      wb_sel  <= 4'h0;
      wb_we   <= 1'b0;
      wb_cyc  <= 1'b0;
      wb_stb  <= 1'b0;
      aen     <= 2'h0;
      te      <= 2'h0;
      stp     <= 1'b0;
      pin     <= 2'h3;
      for (int k = 0; k < 5; k++) m_cfg[k] = 2'h0;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      void'($urandom(13));
      // reset values, unmapped place, refused writes
      for (int k = 0; k < 9; k++) begin
         wb_rd(hvi_pkg::IDX_INPUT_STATE + 12'(k), rd);
         check("reset read", rd, (k == 0) ? 32'h0000_0003 : 32'h0000_0000);
      end
      check("reset pad", 32'(pad_ctrl), 32'h0000_0000);
      wb_wr(hvi_pkg::IDX_INPUT_STATE, 32'h0000_0000, 4'hF);
      wb_rd(hvi_pkg::IDX_INPUT_STATE, rd);
      check("input state write", rd, 32'h0000_0003);
      wb_wr(hvi_pkg::IDX_PULL_SELECT, 32'hFFFF_FFFF, 4'hE);
      wb_rd(hvi_pkg::IDX_PULL_SELECT, rd);
      check("sel0 low write", rd, 32'h0000_0000);
      // random configurations against the reference
      for (int it = 0; it < 80; it++) begin
         for (int k = 0; k < 5; k++) begin
            d = $urandom;
            m_cfg[k] = d[1:0];
            wb_wr(hvi_pkg::IDX_PULL_SELECT + 12'(k), d, 4'hF);
         end
         aen <= 2'($urandom);
         te  <= 2'($urandom);
         stp <= 1'($urandom);
         pin <= 2'($urandom);
         repeat (4) @(posedge sys_clk);
         check("pad ctrl", 32'(pad_ctrl), exp_pad());
         wb_rd(hvi_pkg::IDX_INPUT_STATE, rd);
         check("input state", rd, exp_input());
         for (int k = 0; k < 5; k++) begin
            wb_rd(hvi_pkg::IDX_PULL_SELECT + 12'(k), rd);
            check("config readback", rd, {30'h0, m_cfg[k]});
         end
         check("irq masked", {31'h0, irq}, 32'h0000_0000);
      end
      // edge interrupts: pin 0 rising, pin 1 falling
      aen <= 2'h0;
      stp <= 1'b0;
      pin <= 2'h0;
      wb_wr(hvi_pkg::IDX_DIGITAL_EN, 32'h0000_0003, 4'hF);
      wb_wr(hvi_pkg::IDX_EDGE_POLARITY, 32'h0000_0001, 4'hF);
      wb_wr(hvi_pkg::IDX_IRQ_MASK, 32'h0000_0000, 4'hF);
      repeat (4) @(posedge sys_clk);
      wb_wr(hvi_pkg::IDX_IRQ_STATUS, 32'h0000_0003, 4'hF);
      pin <= 2'h3;
      repeat (4) @(posedge sys_clk);
      wb_rd(hvi_pkg::IDX_IRQ_STATUS, rd);
      check("rising edge status", rd, 32'h0000_0001);
      check("irq while masked", {31'h0, irq}, 32'h0000_0000);
      wb_wr(hvi_pkg::IDX_IRQ_MASK, 32'h0000_0003, 4'hF);
      repeat (2) @(posedge sys_clk);
      check("irq unmasked", {31'h0, irq}, 32'h0000_0001);
      pin <= 2'h0;
      repeat (4) @(posedge sys_clk);
      wb_rd(hvi_pkg::IDX_IRQ_STATUS, rd);
      check("falling edge status", rd, 32'h0000_0003);
      wb_wr(hvi_pkg::IDX_IRQ_STATUS, 32'h0000_0001, 4'hF);
      wb_rd(hvi_pkg::IDX_IRQ_STATUS, rd);
      check("one bit cleared", rd, 32'h0000_0002);
      wb_wr(hvi_pkg::IDX_IRQ_MASK, 32'h0000_0001, 4'hF);
      repeat (2) @(posedge sys_clk);
      check("irq after mask", {31'h0, irq}, 32'h0000_0000);
      wb_wr(hvi_pkg::IDX_IRQ_STATUS, 32'h0000_0002, 4'hF);
      wb_rd(hvi_pkg::IDX_IRQ_STATUS, rd);
      check("all cleared", rd, 32'h0000_0000);
      results();
   end
endmodule
